// *** core/tdc_slave.sv ***
// What this block does
// - Fine tap counter plus coarse counter, one clock.
// - Reference select sets fine bin step.
// - Hit latches fine and coarse time.
// - Edge mode: leading, trailing, both, pair.
// - Four hits per channel, shared level-one buffer.
// - Transfer tags channel, adds eight-bit offset.
// - Hit on full channel is dropped.
// - Continuous mode forwards buffer to readout.
// - Trigger queue of sixteen, window selects hits.
// - Readout FIFO 256 deep, depth limit configurable.
// - Token from master, returned after data.
// - Word moves on ready and get handshake.
// - Token kept per mode until done.
// - Setup scan 646 plus parity, locked while running.
// - Control scan 38 plus parity, live enables.
// - Parity checked always, sticky errors, status readable.
// - Event reset loads event offset.
// - Bunch reset loads coarse, bunch, reject offsets.
// - Global reset empties buffers, clears errors.
// - Mode change flushes all held data.
// - Continuous data has no header or trailer.
// - Trigger or readout overflow sets overflow flag; readout overflow also writes error word.
`timescale 1ns/100ps
`include "tdc_consts.svh"
module tdc_slave import tdc_pkg::*; #(
	parameter int NCH = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	tdc_link_if.device link,
	input wire logic [NCH-1:0] i_hit,
	input wire logic i_trigger,
	output logic o_setup_parity_err,
	output logic o_ctrl_parity_err,
	output logic o_overflow,
	output logic [`L1_AW:0] o_l1_count,
	output logic [`TRIG_AW:0] o_trig_count,
	output logic [`RO_AW:0] o_ro_count
);
	typedef struct packed {
		logic [NCH-1:0] s1, s2, s3, lvl;
		logic t1, t2, t3, tlvl;
		logic [`SETUP_BITS:0] su_sr, su;
		logic [`CTRL_BITS:0] ct_sr, ct;
		logic su_err, ct_err;
		logic [`FINE_W-1:0] fine;
		logic [`COARSE_W-1:0] coarse, bunch, reject, evid, cur_bid, cur_ev, ev_cnt;
		logic [NCH-1:0][`TIME_W-1:0] lead;
		logic [NCH-1:0][2:0] hcnt;
		logic [NCH-1:0][`HIT_DEPTH-1:0][`HQ_W-1:0] hq;
		logic [`L1_AW:0] l1_wr, l1_rd;
		logic [`TRIG_AW:0] tf_wr, tf_rd;
		logic [`RO_AW:0] ro_wr, ro_rd;
		logic ovf, err_pend, tok_out;
		match_state_t ms;
		tok_state_t ts;
	} st_t;

	st_t st, n;
	logic [`ENTRY_W-1:0] l1_mem [0:(1<<`L1_AW)-1];
	logic [2*`COARSE_W-1:0] tf_mem [0:(1<<`TRIG_AW)-1];
	logic [`WORD_W-1:0] ro_mem [0:(1<<`RO_AW)-1];
	logic l1_we, tf_we, ro_we, want, src_go;
	logic [`ENTRY_W-1:0] l1_wd;
	logic [`WORD_W-1:0] ro_wd, word;

	always_comb begin
		logic [NCH-1:0] agree, rise, fall;
		logic ta, trig, running, found, flush, rec, empty, done;
		logic [`FINE_W:0] fsum;
		logic [`FINE_W-1:0] step;
		logic [`TIME_W-1:0] now;
		logic [`HQ_W-1:0] ent;
		logic [`ENTRY_W-1:0] head;
		logic [`L1_AW:0] l1_cnt;
		logic [`RO_AW:0] ro_cnt, ro_lim;
		logic [`COARSE_W-1:0] win_lo;
		edge_mode_t em;
		n = st;
		l1_we = 1'b0;
		tf_we = 1'b0;
		ro_we = 1'b0;
		want = 1'b0;
		word = '0;
		l1_wd = '0;
		ro_wd = '0;
		found = 1'b0;
		done = 1'b0;
		rec = 1'b0;
		ent = '0;
		em = EDGE_LEAD;
		step = `FINE_STEP_40;
		n.tok_out = 1'b0;
		// A pin change counts only once the second and third stages agree.
		n.s1 = i_hit;
		n.s2 = st.s1;
		n.s3 = st.s2;
		agree = ~(st.s2 ^ st.s3);
		rise = agree & st.s3 & ~st.lvl;
		fall = agree & ~st.s3 & st.lvl;
		n.lvl = (st.lvl & ~agree) | (st.s3 & agree);
		n.t1 = i_trigger;
		n.t2 = st.t1;
		n.t3 = st.t2;
		ta = (st.t2 == st.t3);
		trig = ta & st.t3 & ~st.tlvl;
		n.tlvl = ta ? st.t3 : st.tlvl;

		running = ~st.ct[`CT_PLL_INIT] & (|st.ct[`CT_ENABLE_LSB +: NCH]);
		if (link.setup_shift) n.su_sr = {link.scan_sdi, st.su_sr[`SETUP_BITS:1]};
		if (link.setup_load && !running) n.su = st.su_sr;
		if (link.ctrl_shift) n.ct_sr = {link.scan_sdi, st.ct_sr[`CTRL_BITS:1]};
		if (link.ctrl_load) n.ct = st.ct_sr;
		if (^st.su) n.su_err = 1'b1;
		if (^st.ct) n.ct_err = 1'b1;
		flush = link.setup_load && !running && (st.su_sr[`SU_MODE] != st.su[`SU_MODE]);

		unique case (st.ct[`CT_CLKSEL_LSB +: 2])
			`CLKSEL_160: step = `FINE_STEP_160;
			`CLKSEL_320: step = `FINE_STEP_320;
			default: step = `FINE_STEP_40;
		endcase
		fsum = {1'b0, st.fine} + {1'b0, step};
		now = {st.coarse, st.fine};
		if (st.ct[`CT_PLL_INIT]) begin
			n.fine = '0;
		end else begin
			n.fine = fsum[`FINE_W-1:0];
			if (fsum[`FINE_W]) begin
				n.coarse = st.coarse + 1'b1;
				n.bunch = st.bunch + 1'b1;
				n.reject = st.reject + 1'b1;
			end
		end
		if (link.bcnt_rst) begin
			n.fine = '0;
			n.coarse = st.su[`SU_BCOFF_LSB +: `COARSE_W];
			n.bunch = st.su[`SU_BCOFF_LSB +: `COARSE_W];
			n.reject = st.su[`SU_REJOFF_LSB +: `COARSE_W];
		end

		l1_cnt = st.l1_wr - st.l1_rd;
		// Lowest channel wins the transfer slot; high rates on one channel can starve the others.
		for (int i = 0; i < NCH; i++) begin
			if (!found && st.hcnt[i] != 3'h0 && l1_cnt[`L1_AW] == 1'b0) begin
				found = 1'b1;
				l1_we = 1'b1;
				l1_wd = {st.hq[i][0][`HQ_W-1:`TIME_W], i[2:0],
					st.hq[i][0][`TIME_W-1:0] + {{(`TIME_W-8){1'b0}}, st.su[`SU_OFFSET_LSB+8*i +: 8]}};
				for (int k = 0; k < `HIT_DEPTH-1; k++) n.hq[i][k] = st.hq[i][k+1];
				n.hcnt[i] = st.hcnt[i] - 3'h1;
			end
		end
		for (int i = 0; i < NCH; i++) begin
			em = edge_mode_t'(st.su[`SU_EDGE_LSB+2*i +: 2]);
			rec = 1'b0;
			ent = {9'h000, now};
			if (st.ct[`CT_ENABLE_LSB+i]) begin
				if (rise[i] && (em == EDGE_LEAD || em == EDGE_BOTH)) rec = 1'b1;
				if (fall[i] && (em == EDGE_TRAIL || em == EDGE_BOTH)) begin
					rec = 1'b1;
					ent = {9'h001, now};
				end
				if (rise[i] && em == EDGE_PAIR) n.lead[i] = now;
				if (fall[i] && em == EDGE_PAIR) begin
					rec = 1'b1;
					ent = {8'(now - st.lead[i]), 1'b0, st.lead[i]};
				end
			end
			if (rec && n.hcnt[i] < 3'(`HIT_DEPTH)) begin
				n.hq[i][n.hcnt[i][1:0]] = ent;
				n.hcnt[i] = n.hcnt[i] + 3'h1;
			end
		end

		if (trig && st.su[`SU_MODE]) begin
			if (st.tf_wr - st.tf_rd != 5'h10) begin
				tf_we = 1'b1;
				n.tf_wr = st.tf_wr + 1'b1;
			end else begin
				n.ovf = 1'b1;
			end
			n.evid = st.evid + 1'b1;
		end
		if (link.evcnt_rst) n.evid = st.su[`SU_EVOFF_LSB +: `COARSE_W];

		ro_cnt = st.ro_wr - st.ro_rd;
		ro_lim = (st.su[`SU_RO_DEPTH_LSB +: 8] == 8'h00) ? 9'h100 : {1'b0, st.su[`SU_RO_DEPTH_LSB +: 8]};
		src_go = !(st.err_pend && ro_cnt < ro_lim);
		head = l1_mem[st.l1_rd[`L1_AW-1:0]];
		win_lo = st.cur_bid - st.su[`SU_WIN_LSB +: `COARSE_W];
		if (!st.su[`SU_MODE]) begin
			if (src_go && l1_cnt != '0) begin
				n.l1_rd = st.l1_rd + 1'b1;
				want = 1'b1;
				word = {`TYPE_DATA, 1'b0, head};
			end
		end else begin
			unique case (st.ms)
				M_IDLE: begin
					if (st.tf_wr != st.tf_rd) begin
						{n.cur_bid, n.cur_ev} = tf_mem[st.tf_rd[`TRIG_AW-1:0]];
						n.tf_rd = st.tf_rd + 1'b1;
						n.ev_cnt = '0;
						n.ms = M_HEAD;
					end else if (l1_cnt != '0 && head[`TIME_W-1:`FINE_W] < st.reject) begin
						n.l1_rd = st.l1_rd + 1'b1;
					end
				end
				M_HEAD: begin
					if (src_go) begin
						want = 1'b1;
						word = {`TYPE_HEAD, 6'h00, st.cur_ev, st.cur_bid};
						n.ms = M_SCAN;
					end
				end
				M_SCAN: begin
					// Hits still in the channel registers are not waited for; widen the window if they matter.
					if (l1_cnt == '0 || head[`TIME_W-1:`FINE_W] > st.cur_bid) begin
						n.ms = M_TRAIL;
					end else if (src_go) begin
						n.l1_rd = st.l1_rd + 1'b1;
						if (head[`TIME_W-1:`FINE_W] >= win_lo) begin
							want = 1'b1;
							word = {`TYPE_DATA, 1'b0, head};
							n.ev_cnt = st.ev_cnt + 1'b1;
						end
					end
				end
				M_TRAIL: begin
					if (src_go) begin
						want = 1'b1;
						word = {`TYPE_TRAIL, st.ovf, 5'h00, st.cur_ev, st.ev_cnt};
						n.ms = M_IDLE;
					end
				end
			endcase
		end
		if (!src_go) begin
			ro_we = 1'b1;
			ro_wd = {`TYPE_ERR, `ERR_OVERFLOW};
			n.err_pend = 1'b0;
		end else if (want) begin
			if (ro_cnt < ro_lim) begin
				ro_we = 1'b1;
				ro_wd = word;
			end else begin
				n.ovf = 1'b1;
				n.err_pend = 1'b1;
			end
		end
		if (ro_we) n.ro_wr = st.ro_wr + 1'b1;
		if (l1_we) n.l1_wr = st.l1_wr + 1'b1;

		empty = (ro_cnt == '0);
		unique case (st.ts)
			T_IDLE: if (link.token_to_slave) n.ts = T_HOLD;
			T_HOLD: begin
				if (link.get_data && !empty) n.ro_rd = st.ro_rd + 1'b1;
				if (st.su[`SU_MODE]) begin
					done = (link.get_data && !empty && link.data[31:30] == `TYPE_TRAIL) ||
						(empty && st.ms == M_IDLE && st.tf_wr == st.tf_rd);
				end else begin
					done = empty || (!st.su[`SU_KEEP_TOK] && link.get_data);
				end
				if (done) begin
					n.ts = T_IDLE;
					n.tok_out = 1'b1;
				end
			end
		endcase

		if (link.global_rst || flush) begin
			n.l1_rd = '0;
			n.l1_wr = '0;
			n.tf_rd = '0;
			n.tf_wr = '0;
			n.ro_rd = '0;
			n.ro_wr = '0;
			n.hcnt = '0;
			n.ms = M_IDLE;
			n.err_pend = 1'b0;
			n.ovf = 1'b0;
		end
		if (link.global_rst) begin
			n.ts = T_IDLE;
			n.tok_out = 1'b0;
			n.fine = '0;
			n.coarse = '0;
			n.bunch = '0;
			n.reject = '0;
			n.evid = '0;
			n.su_err = 1'b0;
			n.ct_err = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			st <= '0;
		end else if (i_ce) begin
			st <= n;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset && i_ce) begin
			if (l1_we) l1_mem[st.l1_wr[`L1_AW-1:0]] <= l1_wd;
			if (tf_we) tf_mem[st.tf_wr[`TRIG_AW-1:0]] <= {st.bunch, st.evid};
			if (ro_we) ro_mem[st.ro_wr[`RO_AW-1:0]] <= ro_wd;
		end
	end

	assign link.data_ready = (st.ts == T_HOLD) && (st.ro_wr != st.ro_rd);
	assign link.data = ro_mem[st.ro_rd[`RO_AW-1:0]];
	assign link.token_from_slave = st.tok_out;
	assign o_setup_parity_err = st.su_err;
	assign o_ctrl_parity_err = st.ct_err;
	assign o_overflow = st.ovf;
	assign o_l1_count = st.l1_wr - st.l1_rd;
	assign o_trig_count = st.tf_wr - st.tf_rd;
	assign o_ro_count = st.ro_wr - st.ro_rd;
endmodule

// *** core/tdc_consts.svh ***
`ifndef TDC_CONSTS_SVH
`define TDC_CONSTS_SVH
`define FINE_W 5
`define COARSE_W 12
`define TIME_W 17
`define HQ_W 26
`define ENTRY_W 29
`define WORD_W 32
`define HIT_DEPTH 4
`define L1_AW 8
`define TRIG_AW 4
`define RO_AW 8
`define SETUP_BITS 646
`define CTRL_BITS 38
`define SU_OFFSET_LSB 0
`define SU_EDGE_LSB 64
`define SU_MODE 80
`define SU_KEEP_TOK 81
`define SU_RO_DEPTH_LSB 82
`define SU_WIN_LSB 90
`define SU_EVOFF_LSB 102
`define SU_BCOFF_LSB 114
`define SU_REJOFF_LSB 126
`define CT_ENABLE_LSB 0
`define CT_CLKSEL_LSB 35
`define CT_PLL_INIT 37
`define CLKSEL_160 2'h2
`define CLKSEL_320 2'h3
`define FINE_STEP_40 5'h08
`define FINE_STEP_160 5'h02
`define FINE_STEP_320 5'h01
`define TYPE_DATA 2'h0
`define TYPE_HEAD 2'h1
`define TYPE_TRAIL 2'h2
`define TYPE_ERR 2'h3
`define ERR_OVERFLOW 30'h00000001
`endif

// *** core/tdc_pkg.sv ***
package tdc_pkg;
	typedef enum logic [1:0] {EDGE_LEAD, EDGE_TRAIL, EDGE_BOTH, EDGE_PAIR} edge_mode_t;
	typedef enum logic [1:0] {M_IDLE, M_HEAD, M_SCAN, M_TRAIL} match_state_t;
	typedef enum logic {T_IDLE, T_HOLD} tok_state_t;
	typedef enum logic {R_IDLE, R_WAIT} ro_state_t;
	typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_LOAD} scan_state_t;
endpackage

// *** core/tdc_link_if.sv ***
`timescale 1ns/100ps
interface tdc_link_if;
	logic token_to_slave;
	logic token_from_slave;
	logic data_ready;
	logic get_data;
	logic [31:0] data;
	logic scan_sdi;
	logic setup_shift;
	logic setup_load;
	logic ctrl_shift;
	logic ctrl_load;
	logic evcnt_rst;
	logic bcnt_rst;
	logic global_rst;
	modport device(input token_to_slave, get_data, scan_sdi, setup_shift, setup_load, ctrl_shift, ctrl_load,
		evcnt_rst, bcnt_rst, global_rst, output token_from_slave, data_ready, data);
	modport master(output token_to_slave, get_data, scan_sdi, setup_shift, setup_load, ctrl_shift, ctrl_load,
		evcnt_rst, bcnt_rst, global_rst, input token_from_slave, data_ready, data);
endinterface

// *** core/tdc_readout_master.sv ***
`timescale 1ns/100ps
`include "tdc_consts.svh"
module tdc_readout_master import tdc_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	tdc_link_if.master link,
	input wire logic i_readout_start,
	output logic [`WORD_W-1:0] o_word,
	output logic o_word_valid,
	output logic o_readout_done,
	output logic o_readout_busy,
	input wire logic [`SETUP_BITS-1:0] i_setup_cfg,
	input wire logic i_setup_go,
	input wire logic [`CTRL_BITS-1:0] i_ctrl_cfg,
	input wire logic i_ctrl_go,
	output logic o_scan_busy,
	input wire logic i_evcnt_rst,
	input wire logic i_bcnt_rst,
	input wire logic i_global_rst
);
	typedef struct packed {
		ro_state_t rs;
		logic tok, valid, done;
		logic [`WORD_W-1:0] word;
		scan_state_t ss;
		logic sel_ctrl, sdi, su_shift, ct_shift, su_load, ct_load;
		logic [`SETUP_BITS:0] sr;
		logic [9:0] cnt;
		logic evr, bcr, glr;
	} st_t;

	st_t st, n;
	logic get;

	assign get = (st.rs == R_WAIT) && link.data_ready;

	always_comb begin
		n = st;
		n.tok = 1'b0;
		n.valid = 1'b0;
		n.done = 1'b0;
		n.su_shift = 1'b0;
		n.ct_shift = 1'b0;
		n.su_load = 1'b0;
		n.ct_load = 1'b0;
		n.evr = i_evcnt_rst;
		n.bcr = i_bcnt_rst;
		n.glr = i_global_rst;
		unique case (st.rs)
			R_IDLE: begin
				if (i_readout_start) begin
					n.tok = 1'b1;
					n.rs = R_WAIT;
				end
			end
			R_WAIT: begin
				if (get) begin
					n.word = link.data;
					n.valid = 1'b1;
				end
				if (link.token_from_slave) begin
					n.done = 1'b1;
					n.rs = R_IDLE;
				end
			end
		endcase
		// Parity makes the whole path, parity bit included, even.
		unique case (st.ss)
			S_IDLE: begin
				if (i_setup_go) begin
					n.sr = {^i_setup_cfg, i_setup_cfg};
					n.cnt = 10'(`SETUP_BITS + 1);
					n.sel_ctrl = 1'b0;
					n.ss = S_SHIFT;
				end else if (i_ctrl_go) begin
					n.sr = {{(`SETUP_BITS-`CTRL_BITS){1'b0}}, ^i_ctrl_cfg, i_ctrl_cfg};
					n.cnt = 10'(`CTRL_BITS + 1);
					n.sel_ctrl = 1'b1;
					n.ss = S_SHIFT;
				end
			end
			S_SHIFT: begin
				n.sdi = st.sr[0];
				n.sr = st.sr >> 1;
				n.su_shift = !st.sel_ctrl;
				n.ct_shift = st.sel_ctrl;
				n.cnt = st.cnt - 10'h001;
				if (st.cnt == 10'h001) n.ss = S_LOAD;
			end
			S_LOAD: begin
				n.su_load = !st.sel_ctrl;
				n.ct_load = st.sel_ctrl;
				n.ss = S_IDLE;
			end
			default: n.ss = S_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			st <= '0;
		end else if (i_ce) begin
			st <= n;
		end
	end

	assign link.token_to_slave = st.tok;
	assign link.get_data = get;
	assign link.scan_sdi = st.sdi;
	assign link.setup_shift = st.su_shift;
	assign link.ctrl_shift = st.ct_shift;
	assign link.setup_load = st.su_load;
	assign link.ctrl_load = st.ct_load;
	assign link.evcnt_rst = st.evr;
	assign link.bcnt_rst = st.bcr;
	assign link.global_rst = st.glr;
	assign o_word = st.word;
	assign o_word_valid = st.valid;
	assign o_readout_done = st.done;
	assign o_readout_busy = (st.rs == R_WAIT);
	assign o_scan_busy = (st.ss != S_IDLE);
endmodule

// *** verif/tdc_link_asserts.sv ***
`timescale 1ns/100ps
module tdc_link_asserts (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic token_to_slave,
	input wire logic token_from_slave,
	input wire logic data_ready,
	input wire logic get_data,
	input wire logic scan_sdi,
	input wire logic setup_shift,
	input wire logic setup_load,
	input wire logic ctrl_shift,
	input wire logic ctrl_load,
	input wire logic global_rst
);
	logic [9:0] setup_cnt_ff;
	logic [9:0] ctrl_cnt_ff;
	logic parity_ff;
	logic held_ff;

	// Run lengths restart on every gap, so a short or split burst cannot reach the full count.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			setup_cnt_ff <= 10'h000;
			ctrl_cnt_ff <= 10'h000;
			parity_ff <= 1'b0;
			held_ff <= 1'b0;
		end else begin
			setup_cnt_ff <= setup_shift ? setup_cnt_ff + 10'h001 : 10'h000;
			ctrl_cnt_ff <= ctrl_shift ? ctrl_cnt_ff + 10'h001 : 10'h000;
			parity_ff <= (setup_shift | ctrl_shift) ? parity_ff ^ scan_sdi : 1'b0;
			held_ff <= token_to_slave | (held_ff & ~token_from_slave);
		end
	end

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_reset);

	chk_get_needs_ready: assert property (get_data |-> data_ready)
		else $error("get without ready");
	chk_ready_in_token: assert property (data_ready |-> held_ff)
		else $error("ready without token");
	chk_token_comes_back: assert property (token_to_slave |-> ##[1:600] token_from_slave)
		else $error("token not returned");
	chk_return_pulse: assert property (token_from_slave |=> !token_from_slave)
		else $error("return longer than one cycle");
	chk_grant_pulse: assert property (token_to_slave |=> !token_to_slave)
		else $error("grant longer than one cycle");
	chk_setup_length: assert property (setup_load |-> setup_cnt_ff == 10'h287)
		else $error("setup path length wrong");
	chk_ctrl_length: assert property (ctrl_load |-> ctrl_cnt_ff == 10'h027)
		else $error("control path length wrong");
	chk_scan_even_parity: assert property ((setup_load || ctrl_load) |-> !parity_ff)
		else $error("scan parity odd");
	chk_shift_burst: assert property ($rose(setup_shift) |-> setup_shift[*8])
		else $error("setup burst broken");
	chk_global_idle: assert property (global_rst |=> !data_ready)
		else $error("ready after global reset");

	cover property (data_ready && get_data);
	cover property (setup_load);
	cover property (ctrl_load);
	cover property (token_from_slave);
endmodule

// *** verif/test_multihit_tdc_capture_readout.sv ***
`timescale 1ns/100ps
`include "tdc_consts.svh"
module test_multihit_tdc_capture_readout;
	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] hit = 8'h00;
	logic [`SETUP_BITS-1:0] setup_cfg = '0;
	logic [`CTRL_BITS-1:0] ctrl_cfg = '0;
	logic setup_go = 1'b0;
	logic ctrl_go = 1'b0;
	logic ro_start = 1'b0;
	logic bcnt_rst = 1'b0;
	logic evcnt_rst = 1'b0;
	logic trigger = 1'b0;
	logic global_rst = 1'b0;
	logic [`WORD_W-1:0] word;
	logic word_valid, ro_done, ro_busy, scan_busy, setup_err, ctrl_err, overflow;
	logic [`L1_AW:0] l1_count;
	logic [`TRIG_AW:0] trig_count;
	logic [`RO_AW:0] ro_count;
	logic [`WORD_W-1:0] words [$];
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;

	always #10 i_sys_clk = ~i_sys_clk;

	tdc_link_if tdc_link_if_inst();
	tdc_slave #(.NCH(8)) tdc_slave_inst(.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ce(1'b1),
		.link(tdc_link_if_inst), .i_hit(hit), .i_trigger(trigger), .o_setup_parity_err(setup_err),
		.o_ctrl_parity_err(ctrl_err), .o_overflow(overflow), .o_l1_count(l1_count),
		.o_trig_count(trig_count), .o_ro_count(ro_count));
	tdc_readout_master tdc_readout_master_inst(.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ce(1'b1),
		.link(tdc_link_if_inst), .i_readout_start(ro_start), .o_word(word), .o_word_valid(word_valid),
		.o_readout_done(ro_done), .o_readout_busy(ro_busy), .i_setup_cfg(setup_cfg), .i_setup_go(setup_go),
		.i_ctrl_cfg(ctrl_cfg), .i_ctrl_go(ctrl_go), .o_scan_busy(scan_busy), .i_evcnt_rst(evcnt_rst),
		.i_bcnt_rst(bcnt_rst), .i_global_rst(global_rst));
	tdc_link_asserts tdc_link_asserts_inst(.i_sys_clk(i_sys_clk), .i_reset(i_reset),
		.token_to_slave(tdc_link_if_inst.token_to_slave), .token_from_slave(tdc_link_if_inst.token_from_slave),
		.data_ready(tdc_link_if_inst.data_ready), .get_data(tdc_link_if_inst.get_data),
		.scan_sdi(tdc_link_if_inst.scan_sdi), .setup_shift(tdc_link_if_inst.setup_shift),
		.setup_load(tdc_link_if_inst.setup_load), .ctrl_shift(tdc_link_if_inst.ctrl_shift),
		.ctrl_load(tdc_link_if_inst.ctrl_load), .global_rst(tdc_link_if_inst.global_rst));

	task automatic mismatch(input string msg);
		miscompares++;
		$display("unexpected at %0t ns: %s", $time, msg);
	endtask

	task automatic final_report();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Outputs are sampled on the falling edge so they have settled after the rising edge.
	task automatic scan(input logic is_setup, output int n);
		@(posedge i_sys_clk);
		if (is_setup) setup_go <= 1'b1;
		else ctrl_go <= 1'b1;
		@(posedge i_sys_clk);
		setup_go <= 1'b0;
		ctrl_go <= 1'b0;
		n = 0;
		do begin
			@(negedge i_sys_clk);
			n++;
		end while (scan_busy !== 1'b0 && n < 800);
	endtask

	task automatic wait_ro(input logic [`RO_AW:0] level);
		int n;
		n = 0;
		while (ro_count !== level && n < 100) begin
			@(negedge i_sys_clk);
			n++;
		end
		comparisons++;
		if (ro_count !== level) mismatch("readout fifo level");
	endtask

	task automatic readout();
		int n;
		@(posedge i_sys_clk);
		ro_start <= 1'b1;
		@(posedge i_sys_clk);
		ro_start <= 1'b0;
		words.delete();
		n = 0;
		do begin
			@(negedge i_sys_clk);
			n++;
			if (word_valid === 1'b1) words.push_back(word);
		end while (ro_done !== 1'b1 && n < 400);
		comparisons++;
		if (n >= 400) mismatch("readout never finished");
		comparisons++;
		if (ro_busy !== 1'b0) mismatch("master still busy");
	endtask

	task automatic test_configure();
		int n;
		setup_cfg[`SU_OFFSET_LSB+8 +: 8] <= 8'h40;
		setup_cfg[`SU_EDGE_LSB+4 +: 2] <= 2'h1;
		setup_cfg[`SU_KEEP_TOK] <= 1'b1;
		scan(1'b1, n);
		comparisons++;
		if (n < 647 || n > 660) mismatch("setup scan length");
		ctrl_cfg[`CT_ENABLE_LSB +: 8] <= 8'h07;
		scan(1'b0, n);
		comparisons++;
		if (n < 39 || n > 52) mismatch("control scan length");
		comparisons++;
		if (setup_err !== 1'b0 || ctrl_err !== 1'b0) mismatch("parity error flagged");
		$display("test_configure done");
	endtask

	// Channels 0 and 1 record leading edges together; channel 2 records only its trailing edge.
	task automatic test_continuous_hits();
		logic [16:0] d;
		@(posedge i_sys_clk);
		hit <= 8'h07;
		repeat (10) @(posedge i_sys_clk);
		hit <= 8'h04;
		repeat (10) @(posedge i_sys_clk);
		hit <= 8'h00;
		wait_ro(9'h003);
		readout();
		comparisons++;
		if (words.size() !== 3) mismatch("word count");
		for (int i = 0; i < words.size() && i < 3; i++) begin
			comparisons++;
			if (words[i][31:30] !== `TYPE_DATA) mismatch("word type");
			comparisons++;
			if (words[i][19:17] !== i[2:0]) mismatch("channel tag or order");
			comparisons++;
			if (words[i][20] !== (i == 2)) mismatch("edge kind");
		end
		if (words.size() == 3) begin
			d = words[1][16:0] - words[0][16:0];
			comparisons++;
			if (d !== 17'h00040) mismatch("channel offset");
			d = words[2][16:0] - words[0][16:0];
			comparisons++;
			if (d < 20 * `FINE_STEP_40 - 8 || d > 20 * `FINE_STEP_40 + 8) mismatch("time step");
		end
		$display("test_continuous_hits done");
	endtask

	task automatic test_global_reset();
		@(posedge i_sys_clk);
		hit <= 8'h01;
		repeat (3) @(posedge i_sys_clk);
		hit <= 8'h00;
		wait_ro(9'h001);
		@(posedge i_sys_clk);
		global_rst <= 1'b1;
		@(posedge i_sys_clk);
		global_rst <= 1'b0;
		repeat (4) @(negedge i_sys_clk);
		comparisons++;
		if (ro_count !== 9'h000 || l1_count !== 9'h000 || overflow !== 1'b0) mismatch("not emptied");
		readout();
		comparisons++;
		if (words.size() !== 0) mismatch("data after global reset");
		$display("test_global_reset done");
	endtask

	// The window is loose because the pin synchroniser and link registers add a few cycles.
	task automatic test_bunch_reset();
		@(posedge i_sys_clk);
		bcnt_rst <= 1'b1;
		@(posedge i_sys_clk);
		bcnt_rst <= 1'b0;
		repeat (9) @(posedge i_sys_clk);
		hit <= 8'h01;
		repeat (3) @(posedge i_sys_clk);
		hit <= 8'h00;
		wait_ro(9'h001);
		readout();
		comparisons++;
		if (words.size() !== 1) mismatch("word count");
		else begin
			comparisons++;
			if (words[0][16:0] < 17'h00040 || words[0][16:0] > 17'h00080) mismatch("time zero");
		end
		$display("test_bunch_reset done");
	endtask

	// The setup path refuses a load while channels run, so they are switched off around the mode change.
	task automatic test_trigger_match();
		int n;
		ctrl_cfg <= '0;
		scan(1'b0, n);
		setup_cfg[`SU_MODE] <= 1'b1;
		setup_cfg[`SU_EVOFF_LSB +: 12] <= 12'h123;
		scan(1'b1, n);
		ctrl_cfg[`CT_ENABLE_LSB +: 8] <= 8'h07;
		scan(1'b0, n);
		@(posedge i_sys_clk);
		evcnt_rst <= 1'b1;
		@(posedge i_sys_clk);
		evcnt_rst <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
		hit <= 8'h01;
		trigger <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		hit <= 8'h00;
		trigger <= 1'b0;
		wait_ro(9'h003);
		readout();
		comparisons++;
		if (words.size() !== 3) mismatch("event word count");
		else begin
			comparisons++;
			if (words[0][31:30] !== `TYPE_HEAD || words[0][23:12] !== 12'h123) mismatch("event header");
			comparisons++;
			if (words[1][31:30] !== `TYPE_DATA || words[1][16:5] !== words[0][11:0]) mismatch("matched hit");
			comparisons++;
			if (words[2][31:30] !== `TYPE_TRAIL || words[2][29:0] !== {6'h00, 12'h123, 12'h001}) mismatch("trailer");
		end
		comparisons++;
		if (trig_count !== 5'h00) mismatch("trigger queue not drained");
		$display("test_trigger_match done");
	endtask

	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatch("timeout");
			final_report();
		end
	end

	initial begin
		repeat (8) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		test_configure();
		test_continuous_hits();
		test_global_reset();
		test_bunch_reset();
		test_trigger_match();
		final_report();
	end
endmodule
